// [pkg/tsom_pkg.sv]
// Purpose: constants and types for the test signal observe mux
// Assumes: axi4-lite register slave, 32-bit data
// Notes: offsets are byte addresses of aligned words
package tsom_pkg;
  // register byte offsets
  localparam logic [7:0] TSOM_ADDR_ROUTE = 8'h00;
  localparam logic [7:0] TSOM_ADDR_DIGI = 8'h04;
  localparam logic [7:0] TSOM_ADDR_ANA = 8'h08;
  localparam logic [7:0] TSOM_ADDR_STATUS = 8'h0C;
  // route register fields
  localparam int TSOM_SRC_LSB = 0;
  localparam int TSOM_SRC_W = 3;
  localparam int TSOM_ROUTE_BIT = 4;
  // reset values
  localparam logic [2:0] TSOM_SRC_RST = 3'h0;
  localparam logic TSOM_ROUTE_RST = 1'b0;
  localparam logic [7:0] TSOM_DIGI_RST = 8'h00;
  localparam logic [3:0] TSOM_ANA_RST = 4'h0;
  // serial path source codes
  localparam logic [2:0] TSOM_SRC_LOW = 3'h0;
  localparam logic [2:0] TSOM_SRC_HIGH = 3'h1;
  localparam logic [2:0] TSOM_SRC_ENV = 3'h2;
  localparam logic [2:0] TSOM_SRC_NRZ = 3'h3;
  localparam logic [2:0] TSOM_SRC_MAN_SUB = 3'h4;
  localparam logic [2:0] TSOM_SRC_MAN = 3'h5;
  // digital probe codes
  localparam logic [7:0] TSOM_DIG_NONE = 8'h00;
  localparam logic [7:0] TSOM_DIG_DATA = 8'hF4;
  localparam logic [7:0] TSOM_DIG_VALID = 8'hE4;
  localparam logic [7:0] TSOM_DIG_COLL = 8'hD4;
  localparam logic [7:0] TSOM_DIG_BCLK = 8'hC4;
  localparam logic [7:0] TSOM_DIG_RD = 8'hD5;
  localparam logic [7:0] TSOM_DIG_WR = 8'hC5;
  localparam logic [7:0] TSOM_DIG_CORE = 8'h96;
  // analog probe
  localparam int TSOM_ANA_NODES = 13;
  localparam logic [3:0] TSOM_ANA_MAX = 4'hC;
  // axi responses
  localparam logic [1:0] TSOM_RESP_OKAY = 2'h0;
  localparam logic [1:0] TSOM_RESP_SLVERR = 2'h2;
endpackage

// [pkg/tsom_sel_if.sv]
// Purpose: select settings passed from register file to the mux
// Assumes: single clock domain
// Notes: plain wires, no timing of its own
`timescale 1ns/1ps
`default_nettype none
interface tsom_sel_if;
  logic route;
  logic [2:0] src;
  logic [7:0] digi;
  logic [3:0] ana;
  modport regs (output route, output src, output digi, output ana);
  modport mux (input route, input src, input digi, input ana);
endinterface // tsom_sel_if
`default_nettype wire

// [rtl/tsom_mux.sv]
// Purpose: choose the observe pin level and analog probe select
// Assumes: all signal inputs already synchronised to clk
// Notes: outputs are registered, one cycle behind the inputs
`timescale 1ns/1ps
`default_nettype none
module tsom_mux
  import tsom_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  tsom_sel_if.mux sel,
  input wire logic envelope,
  input wire logic tx_nrz,
  input wire logic man_sub,
  input wire logic man,
  input wire logic rx_data,
  input wire logic rx_valid,
  input wire logic rx_coll,
  input wire logic bit_clk,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic core_clk_probe,
  output logic observe_pin,
  output logic [3:0] analog_probe_select,
  output logic analog_probe_enable
);
  logic next_obs;
  logic serial_lvl;
  logic digi_lvl;
  logic digi_hit;

  // serial path choice; reserved codes drive low
  always_comb begin
    case (sel.src)
      TSOM_SRC_LOW: serial_lvl = 1'b0;
      TSOM_SRC_HIGH: serial_lvl = 1'b1;
      TSOM_SRC_ENV: serial_lvl = envelope;
      TSOM_SRC_NRZ: serial_lvl = tx_nrz;
      TSOM_SRC_MAN_SUB: serial_lvl = man_sub;
      TSOM_SRC_MAN: serial_lvl = man;
      default: serial_lvl = 1'b0;
    endcase
  end

  // digital probe choice; unlisted codes fall back to serial path
  always_comb begin
    digi_hit = 1'b1;
    case (sel.digi)
      TSOM_DIG_DATA: digi_lvl = rx_data;
      TSOM_DIG_VALID: digi_lvl = rx_valid;
      TSOM_DIG_COLL: digi_lvl = rx_coll;
      TSOM_DIG_BCLK: digi_lvl = bit_clk;
      TSOM_DIG_RD: digi_lvl = rd_strobe;
      TSOM_DIG_WR: digi_lvl = wr_strobe;
      TSOM_DIG_CORE: digi_lvl = core_clk_probe;
      default: begin
        digi_lvl = 1'b0;
        digi_hit = 1'b0;
      end
    endcase
  end

  // route bit overrides the serial select when the digital code is a listed one
  always_comb begin
    if (sel.route && digi_hit) begin
      next_obs = digi_lvl;
    end else begin
      next_obs = serial_lvl;
    end
  end

  // registered pin drive
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      observe_pin <= 1'b0;
    end else begin
      observe_pin <= next_obs;
    end
  end

  // analog node select; reserved codes disable the probe switch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      analog_probe_select <= TSOM_ANA_RST;
      analog_probe_enable <= 1'b0;
    end else begin
      analog_probe_select <= sel.ana;
      analog_probe_enable <= (sel.ana <= TSOM_ANA_MAX);
    end
  end
endmodule // tsom_mux
`default_nettype wire

// [rtl/tsom_top.sv]
// Purpose: test signal observe mux with axi4-lite registers
// Assumes: one clock; only the core clock copy arrives asynchronous
// Notes: software writes selects; status reads back pin state
//
// What this block does
// - route 0: pin follows serial source select
// - route 1: pin carries chosen digital probe
// - digital choice from 8-bit selection register
// - code F4 outputs received bit value
// - code E4 outputs received valid flag
// - code D4 outputs collision in current bit
// - code C4 outputs serial bit clock
// - D5 read strobe, C5 write strobe
// - code 96 outputs core clock
// - code 00 falls back to serial select
// - 4-bit analog select, codes 0 to C
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tsom_top
  import tsom_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // internal sources, same clock
  input wire logic envelope,
  input wire logic tx_nrz,
  input wire logic man_sub,
  input wire logic man,
  input wire logic rx_data,
  input wire logic rx_valid,
  input wire logic rx_coll,
  input wire logic bit_clk,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  // core clock copy from the oscillator, asynchronous to clk
  input wire logic core_clk_in,
  // probe pins
  output logic observe_pin,
  output logic [3:0] analog_probe_select,
  output logic analog_probe_enable
);
  tsom_sel_if sel ();

  logic test_route_select;
  logic [2:0] serial_path_source_select;
  logic [7:0] test_selection_register;
  logic [3:0] ana_reg;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic do_write;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_word;
  logic core_meta;
  logic core_sync;

  // byte-lane test for a field in the low byte
  function automatic logic lane0(input logic [3:0] strb);
    return strb[0];
  endfunction

  // map a byte address to a known register
  function automatic logic addr_known(input logic [7:0] a);
    return (a == TSOM_ADDR_ROUTE) || (a == TSOM_ADDR_DIGI) ||
           (a == TSOM_ADDR_ANA) || (a == TSOM_ADDR_STATUS);
  endfunction

  // two-stage sync of the asynchronous core clock copy
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_meta <= 1'b0;
      core_sync <= 1'b0;
    end else begin
      core_meta <= core_clk_in;
      core_sync <= core_meta;
    end
  end

  // accept address and data independently, one write at a time
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  assign do_write = aw_held && w_held;
  // status is read-only, so writing it answers slverr
  assign wr_ok = addr_known(aw_addr) && (aw_addr != TSOM_ADDR_STATUS);

  // write response once both halves are in
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TSOM_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? TSOM_RESP_OKAY : TSOM_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // select registers; only the low byte lane carries fields
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      test_route_select <= TSOM_ROUTE_RST;
      serial_path_source_select <= TSOM_SRC_RST;
      test_selection_register <= TSOM_DIGI_RST;
      ana_reg <= TSOM_ANA_RST;
    end else if (do_write && lane0(w_strb)) begin
      if (aw_addr == TSOM_ADDR_ROUTE) begin
        test_route_select <= w_data[TSOM_ROUTE_BIT];
        serial_path_source_select <=
          w_data[TSOM_SRC_LSB +: TSOM_SRC_W];
      end else if (aw_addr == TSOM_ADDR_DIGI) begin
        // reserved codes are stored as written; the mux ignores them
        test_selection_register <= w_data[7:0];
      end else if (aw_addr == TSOM_ADDR_ANA) begin
        ana_reg <= w_data[3:0];
      end
    end
  end

  // read data mux
  always_comb begin
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == TSOM_ADDR_ROUTE) begin
      rd_word[TSOM_ROUTE_BIT] = test_route_select;
      rd_word[TSOM_SRC_LSB +: TSOM_SRC_W] = serial_path_source_select;
    end else if (s_axi_araddr == TSOM_ADDR_DIGI) begin
      rd_word[7:0] = test_selection_register;
    end else if (s_axi_araddr == TSOM_ADDR_ANA) begin
      rd_word[3:0] = ana_reg;
    end else if (s_axi_araddr == TSOM_ADDR_STATUS) begin
      rd_word[0] = observe_pin;
      rd_word[1] = analog_probe_enable;
    end
  end
  assign rd_ok = addr_known(s_axi_araddr);

  // one read at a time; address taken only while no answer pends
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= TSOM_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? TSOM_RESP_OKAY : TSOM_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign sel.route = test_route_select;
  assign sel.src = serial_path_source_select;
  assign sel.digi = test_selection_register;
  assign sel.ana = ana_reg;

  tsom_mux u_mux (
    .clk(clk),
    .arst_n(arst_n),
    .sel(sel.mux),
    .envelope(envelope),
    .tx_nrz(tx_nrz),
    .man_sub(man_sub),
    .man(man),
    .rx_data(rx_data),
    .rx_valid(rx_valid),
    .rx_coll(rx_coll),
    .bit_clk(bit_clk),
    .rd_strobe(rd_strobe),
    .wr_strobe(wr_strobe),
    .core_clk_probe(core_sync),
    .observe_pin(observe_pin),
    .analog_probe_select(analog_probe_select),
    .analog_probe_enable(analog_probe_enable)
  );
endmodule // tsom_top
`default_nettype wire

// [verification/tsom_probe_mon.sv]
// Purpose: test instrument model watching the observe pin
// Assumes: pin sampled on clk, as a logic probe would
// Notes: counts rising edges between clears
`timescale 1ns/1ps
`default_nettype none
module tsom_probe_mon (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic observe_pin,
  input wire logic clr,
  output logic [15:0] rises
);
  logic last;
  // edge counter, cleared by the bench per measurement
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      last <= 1'b0;
      rises <= 16'h0000;
    end else begin
      last <= observe_pin;
      if (clr)
        rises <= 16'h0000;
      else if (observe_pin && !last)
        rises <= rises + 16'h0001;
    end
  end
endmodule // tsom_probe_mon
`default_nettype wire

// [verification/tsom_chk_assertions.sv]
// Purpose: bus handshake and analog probe checks
// Assumes: one clock, async active-low reset
// Notes: sees only top ports, so pin routing is left to the bench
`timescale 1ns/1ps
`default_nettype none
module tsom_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] analog_probe_select,
  input wire logic analog_probe_enable
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // answers stand until taken
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
  a_rvalid_held: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid) else $error("rvalid lost");
  a_ar_refused: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready wrong");
  a_write_busy: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write not refused");
  // both halves taken together: response two edges later
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("bvalid late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("rvalid late");
  a_ana_reserved: assert property (
    analog_probe_select > 4'hC |-> !analog_probe_enable)
    else $error("reserved node enabled");
  a_ana_rise: assert property (
    $rose(analog_probe_enable) |-> analog_probe_select <= 4'hC)
    else $error("enable on bad node");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_ana_off: cover property ($fell(analog_probe_enable));
endmodule // tsom_chk
bind tsom_top tsom_chk u_chk (.clk(clk), .arst_n(arst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .analog_probe_select(analog_probe_select),
  .analog_probe_enable(analog_probe_enable));
`default_nettype wire

// [verification/tsom_top_tb_top.sv]
// Purpose: random and corner tests of the observe mux
// Assumes: register map of tsom_pkg, answers sampled at negedge
// Notes: negedge sample equals the next rising edge value
`timescale 1ns/1ps
`default_nettype none
module tsom_top_tb_top
  import tsom_pkg::*;
;
  logic clk, arst_n, cclk, awv, wv, bre, arv, rre, clr;
  logic awr, wr, bv, arr, rv, pin, ena;
  logic [1:0] br, rr;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd;
  logic [3:0] ws, src_v, asel;
  logic [5:0] dig_v;
  logic [15:0] rises;
  logic [7:0] codes [7] = '{8'hF4, 8'hE4, 8'hD4, 8'hC4, 8'hD5, 8'hC5, 8'h00};
  int num_errors, checked;
  tsom_top dut (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .envelope(src_v[0]), .tx_nrz(src_v[1]),
    .man_sub(src_v[2]), .man(src_v[3]), .rx_data(dig_v[0]),
    .rx_valid(dig_v[1]), .rx_coll(dig_v[2]), .bit_clk(dig_v[3]),
    .rd_strobe(dig_v[4]), .wr_strobe(dig_v[5]), .core_clk_in(cclk),
    .observe_pin(pin), .analog_probe_select(asel),
    .analog_probe_enable(ena));
  tsom_probe_mon u_mon (.clk(clk), .arst_n(arst_n), .observe_pin(pin),
    .clr(clr), .rises(rises));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // core clock copy, deliberately unrelated to clk
  initial begin
    cclk = 1'b0;
    forever #23 cclk = ~cclk;
  end
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e,
      input string m);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic hang();
    num_errors++;
    $display("BAD %0t no answer", $time);
    give_verdict();
  endtask
  // write: both halves offered, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
    int n;
    logic ta, tw, tb;
    @(posedge clk);
    {awa, wd, ws} <= {a, d, s};
    {awv, wv, bre} <= 3'h7;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      {ta, tw, tb, r} = {awr, wr, bv, br};
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) bre <= 1'b0;
      if (tb) break;
    end
    if (n == 40) hang();
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    int n;
    logic ta, tv;
    @(posedge clk);
    ara <= a;
    {arv, rre} <= 2'h3;
    for (n = 0; n < 40; n++) begin
      @(negedge clk);
      {ta, tv, d, r} = {arr, rv, rd, rr};
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (tv) rre <= 1'b0;
      if (tv) break;
    end
    if (n == 40) hang();
  endtask
  // pin is registered: two edges after inputs move it has settled
  task automatic shake();
    @(posedge clk);
    src_v <= 4'($urandom);
    dig_v <= 6'($urandom);
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  function automatic logic exp_ser(input logic [2:0] c,
      input logic [3:0] v);
    if (c == 3'h1) return 1'b1;
    if (c >= 3'h2 && c <= 3'h5) return v[c - 3'h2];
    return 1'b0;
  endfunction
  function automatic logic exp_dig(input logic [7:0] c,
      input logic [5:0] v, input logic f);
    for (int k = 0; k < 6; k++)
      if (c == codes[k]) return v[k];
    return f;
  endfunction
  initial begin
    int i;
    logic [31:0] d;
    logic [1:0] r;
    logic [2:0] s;
    arst_n = 1'b0;
    {awv, wv, bre, arv, rre, clr} = '0;
    {awa, ara, wd, ws, src_v, dig_v} = '0;
    num_errors = 0;
    checked = 0;
    void'($urandom(32'h8554));
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    // reset values; status shows enable set for node 0
    for (i = 0; i < 4; i++) begin
      axr(8'(i * 4), d, r);
      chk(d, (i == 3) ? 32'h2 : 32'h0, "reset value");
    end
    axr(8'h10, d, r);
    chk(d, 32'h0, "unmapped data");
    chk(r, TSOM_RESP_SLVERR, "unmapped resp");
    axw(TSOM_ADDR_STATUS, 32'h3, 4'hF, r);
    chk(r, TSOM_RESP_SLVERR, "status write");
    // route 0 must ignore a live digital code
    axw(TSOM_ADDR_DIGI, 32'h000000F4, 4'hF, r);
    for (i = 0; i < 8; i++) begin
      axw(TSOM_ADDR_ROUTE, 32'(i), 4'hF, r);
      repeat (3) begin
        shake();
        chk(pin, exp_ser(3'(i), src_v), "serial");
      end
    end
    s = 3'($urandom_range(5, 0));
    axw(TSOM_ADDR_ROUTE, (32'h1 << TSOM_ROUTE_BIT) | 32'(s), 4'hF, r);
    for (i = 0; i < 7; i++) begin
      axw(TSOM_ADDR_DIGI, 32'(codes[i]), 4'hF, r);
      axr(TSOM_ADDR_DIGI, d, r);
      chk(d, 32'(codes[i]), "digi reg");
      repeat (3) begin
        shake();
        chk(pin, exp_dig(codes[i], dig_v, exp_ser(s, src_v)),
          "digital");
      end
    end
    // core clock: the instrument must see it toggle
    axw(TSOM_ADDR_DIGI, 32'h00000096, 4'hF, r);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (100) @(posedge clk);
    chk(32'(rises > 16'h000A), 32'h1, "core clock");
    // lane 0 off leaves the code alone
    axw(TSOM_ADDR_DIGI, 32'h0, 4'hE, r);
    axr(TSOM_ADDR_DIGI, d, r);
    chk(d, 32'h00000096, "strobe");
    axw(TSOM_ADDR_DIGI, 32'h0, 4'hF, r);
    for (i = 0; i < 17; i++) begin
      axw(TSOM_ADDR_ANA, 32'(i % 16), 4'hF, r);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(asel, 32'(i % 16), "ana sel");
      chk(ena, 32'((i % 16) <= 12), "ana en");
    end
    give_verdict();
  end
endmodule // tsom_top_tb_top
`default_nettype wire
